// [led_spi_pkg.sv]
// Purpose: Shared constants and types for the LED port expander serial slave.
// Assumes: Serial pins are sampled synchronously on mclk_i.
// Notes: Register storage beyond the serial front end is kept minimal.
package led_spi_pkg;
   localparam int FRAME_BITS = 16;
   localparam int ADDR_BITS = 7;
   localparam int CMD_RW_BIT = 15;
   localparam int ADDR_MSB = 14;
   localparam int ADDR_LSB = 8;
   localparam int REG_COUNT = 128;
   localparam logic [ADDR_BITS-1:0] CFG_ADDR = 7'h10;
   localparam int CFG_OUT_SEL_BIT = 7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [15:0] SHIFT_RESET = 16'h0000;
   localparam logic [1:0] BITCNT_RESET = 2'h0;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } serial_in_type;

   typedef struct packed {
      logic rd_n_wr;
      logic [ADDR_BITS-1:0] addr;
      logic [7:0] data;
   } frame_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_LATCH = 2'b11
   } state_type;
endpackage

// [led_spi_regfile.sv]
// Purpose: Register storage written and read by latched serial frames.
// Assumes: One write strobe per latched write frame.
// Notes: Flip-flop storage addressed by the 7-bit frame address.
module led_spi_regfile
   import led_spi_pkg::*;
(
   input wire logic mclk_i, // System clock.
   input wire logic reset_i, // Asynchronous reset, active high.
   input wire logic wr_en_i, // Write strobe, one cycle.
   input wire logic [ADDR_BITS-1:0] addr_i, // Register index.
   input wire logic [7:0] wdata_i, // Write data.
   output logic [7:0] rdata_o // Combinational read data.
);
   logic [7:0] mem_q [REG_COUNT];

   // Read is a plain index so the latch can sample it on chip select rise.
   assign rdata_o = mem_q[addr_i];

   // Storage updates only on the strobe from a write frame.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            mem_q[i] <= REG_RESET;
         end
      end else if (wr_en_i) begin
         mem_q[addr_i] <= wdata_i;
      end
   end
endmodule

// [led_spi_slave.sv]
// Purpose: Serial slave front end of a ten-port LED driver and expander.
// Assumes: sclk, cs_n and din are synchronous to mclk_i; sclk is slower.
// Notes: Edges of sclk are detected on mclk_i; the serial pin is released only in PWM clock mode.
// How it works
// R1 - Ignore clock and data while select high.
// R2 - Sample serial input on rising clock edge.
// R3 - Frame is command byte then data byte.
// R4 - Bits shift most significant first.
// R5 - D15 low writes data byte on latch.
// R6 - D15 high reads register at address.
// R7 - Read frame data byte is discarded.
// R8 - Read latch loads register into low byte.
// R9 - Master reads result during next frame.
// R10 - Odd clock counts keep last sixteen bits.
// R11 - Output lags input 15.5 clocks, falling edge.
// R12 - Serial output driven in serial mode, released in PWM clock mode.
// R13 - Daisy chain needs sixteen bits per device.
// R14 - Pin is serial output when D7 clear.
// R15 - Power-up pin function is a variant option.
// R16 - Separate selects forbid register reads.
// R17 - Clock low before select falls.
module led_spi_slave
   import led_spi_pkg::*;
#(
   parameter bit OUT_DEFAULT_PWM = 1'b0 // Power-up pin function variant.
)
(
   input wire logic mclk_i, // System clock, 250 MHz.
   input wire logic reset_i, // Asynchronous reset, active high.
   input wire serial_in_type ser_i, // Serial clock, select (low active), data.
   output logic serial_out_o, // Serial data out of the shared pin.
   output logic serial_out_oe_o, // High while the shared pin is driven.
   output logic pwm_clock_sel_o // High while the pin is the PWM clock input.
);
   logic sclk_q;
   logic cs_n_q;
   logic [15:0] shift_q;
   logic [15:0] shift_d;
   logic out_q;
   logic oe_q;
   logic pwm_sel_q;
   logic [1:0] strap_q;
   state_type state_q;
   state_type state_d;
   logic [7:0] rdata;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic selected;
   frame_type frame;
   logic wr_frame;
   logic rd_frame;
   logic cfg_write;
   logic frame_open;

   // Edge detection against last sample of the serial pins.
   assign sclk_rise = ser_i.sclk & ~sclk_q;
   assign sclk_fall = ~ser_i.sclk & sclk_q;
   assign cs_rise = ser_i.cs_n & ~cs_n_q;
   assign selected = ~ser_i.cs_n; // R1
   assign frame = frame_type'(shift_q); // R3
   // Whatever sits in the register at select rise is the frame, however many clocks.
   // A latch closes only a frame that the state machine saw open; any select low sampled
   // after reset opens one, so a stray select rise straight after reset can still write a register.
   assign frame_open = (state_q == ST_SHIFT);
   assign wr_frame = cs_rise & frame_open & ~frame.rd_n_wr; // R5 R10
   assign rd_frame = cs_rise & frame_open & frame.rd_n_wr; // R6 R7
   assign cfg_write = wr_frame & (frame.addr == CFG_ADDR);

   // Shift register: MSB first in, read data loaded into low byte on latch.
   always_comb begin
      shift_d = shift_q;
      if (selected && sclk_rise) begin
         shift_d = {shift_q[14:0], ser_i.din}; // R2 R4
      end else if (rd_frame) begin
         shift_d = {shift_q[15:8], rdata}; // R8 R9
      end
   end

   // Frame tracking state; select rise closes the frame.
   always_comb begin
      case (state_q)
         ST_IDLE: state_d = selected ? ST_SHIFT : ST_IDLE;
         ST_SHIFT: state_d = cs_rise ? ST_LATCH : ST_SHIFT;
         ST_LATCH: state_d = selected ? ST_SHIFT : ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   led_spi_regfile u_regs (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .wr_en_i(wr_frame),
      .addr_i(frame.addr),
      .wdata_i(frame.data),
      .rdata_o(rdata)
   );

   // Pin sampling and shift register.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         shift_q <= SHIFT_RESET;
         state_q <= ST_IDLE;
      end else begin
         sclk_q <= ser_i.sclk;
         cs_n_q <= ser_i.cs_n;
         shift_q <= shift_d;
         state_q <= state_d;
      end
   end

   // The variant strap is caught by a clock after reset release, not by the reset.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         strap_q <= BITCNT_RESET;
         pwm_sel_q <= 1'b0;
      end else begin
         if (strap_q == BITCNT_RESET) begin
            strap_q <= 2'h1;
            pwm_sel_q <= OUT_DEFAULT_PWM; // R15
         end else if (cfg_write) begin
            pwm_sel_q <= frame.data[CFG_OUT_SEL_BIT]; // R14
         end
      end
   end

   // Output bit 15 changes on sclk fall, half a clock after the 16th shift. Releases the
   // pin in PWM clock mode by dropping the enable; in serial output mode it is always driven.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         out_q <= 1'b0;
         oe_q <= 1'b1;
      end else begin
         if (selected && sclk_fall) begin
            out_q <= shift_q[15]; // R11
         end
         oe_q <= ~pwm_sel_q; // R12 R14
      end
   end

   assign serial_out_o = out_q;
   assign serial_out_oe_o = oe_q;
   assign pwm_clock_sel_o = pwm_sel_q;

   property p_ignore_unselected;
      @(posedge mclk_i) disable iff (reset_i)
      (ser_i.cs_n && cs_n_q) |=> (shift_q == $past(shift_q));
   endproperty
   a_ignore_unselected: assert property (p_ignore_unselected) // R1
      else $error("Shift register moved while unselected.");

   property p_sample_rise;
      @(posedge mclk_i) disable iff (reset_i)
      (selected && sclk_rise) |=> (shift_q[0] == $past(ser_i.din))
         && (shift_q[15:1] == $past(shift_q[14:0]));
   endproperty
   a_sample_rise: assert property (p_sample_rise) // R2
      else $error("Serial input not shifted on rising clock.");

   property p_read_load;
      @(posedge mclk_i) disable iff (reset_i)
      rd_frame |=> (shift_q[7:0] == $past(rdata)) && (shift_q[15:8] == $past(shift_q[15:8]));
   endproperty
   a_read_load: assert property (p_read_load) // R8
      else $error("Read data not loaded into low byte.");

   property p_write_store;
      @(posedge mclk_i) disable iff (reset_i)
      wr_frame ##1 (frame.addr == $past(frame.addr)) |-> (rdata == $past(frame.data));
   endproperty
   a_write_store: assert property (p_write_store) // R5
      else $error("Write frame did not store data byte.");

   property p_read_no_write;
      @(posedge mclk_i) disable iff (reset_i)
      rd_frame ##1 (frame.addr == $past(frame.addr)) |-> (rdata == $past(rdata));
   endproperty
   a_read_no_write: assert property (p_read_no_write) // R7
      else $error("Read frame changed a register.");

   property p_out_fall;
      @(posedge mclk_i) disable iff (reset_i)
      (selected && sclk_fall) |=> (serial_out_o == $past(shift_q[15]));
   endproperty
   a_out_fall: assert property (p_out_fall) // R11
      else $error("Serial output not updated on falling clock.");

   property p_out_stable;
      @(posedge mclk_i) disable iff (reset_i)
      !(selected && sclk_fall) |=> $stable(serial_out_o);
   endproperty
   a_out_stable: assert property (p_out_stable) // R11
      else $error("Serial output changed off the falling edge.");

   property p_cfg_select;
      @(posedge mclk_i) disable iff (reset_i)
      cfg_write ##1 (strap_q != BITCNT_RESET)
         |-> ##1 (serial_out_oe_o == ~$past(frame.data[CFG_OUT_SEL_BIT], 2));
   endproperty
   a_cfg_select: assert property (p_cfg_select) // R14
      else $error("Output enable does not follow configuration bit.");

   property p_shift_hold;
      @(posedge mclk_i) disable iff (reset_i)
      (selected && !sclk_rise) |=> (shift_q == $past(shift_q));
   endproperty
   a_shift_hold: assert property (p_shift_hold) // R2
      else $error("Shift register moved without a rising clock.");

   property p_latch_state;
      @(posedge mclk_i) disable iff (reset_i)
      cs_rise |=> (state_q == ST_LATCH);
   endproperty
   a_latch_state: assert property (p_latch_state) // R10
      else $error("Select rise did not close the frame.");

   property p_strap_default;
      @(posedge mclk_i) disable iff (reset_i)
      (strap_q == BITCNT_RESET) && !reset_i |=> (pwm_clock_sel_o == OUT_DEFAULT_PWM);
   endproperty
   a_strap_default: assert property (p_strap_default) // R15
      else $error("Pin function after reset is not the variant default.");
endmodule

// [led_spi_master.sv]
// Purpose: Serial master model that drives clock, select and data into the slave.
// Assumes: Four mclk cycles per clock half keep every level above the two-cycle minimum.
// Notes: The clock rests low between frames; return bits are taken just before each rise.
module led_spi_master
   import led_spi_pkg::*;
(
   input wire logic mclk_i, // System clock.
   input wire logic sdo_i, // Serial data from the slave.
   output serial_in_type ser_o // Clock, select and data to the slave.
);
   timeunit 1ns;
   timeprecision 1ps;
   initial ser_o = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};

   // Shifts the n lowest bits out, most significant first; sel low leaves select high.
   task automatic xfer(input logic [31:0] tx, input int n, input bit sel,
                       output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge mclk_i);
      ser_o.cs_n <= !sel;
      repeat (4) @(posedge mclk_i);
      for (int i = n - 1; i >= 0; i--) begin
         ser_o.din <= tx[i];
         repeat (4) @(posedge mclk_i);
         rx = {rx[14:0], sdo_i};
         ser_o.sclk <= 1'b1;
         repeat (4) @(posedge mclk_i);
         ser_o.sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk_i);
      ser_o.cs_n <= 1'b1;
      repeat (4) @(posedge mclk_i);
   endtask
endmodule

// [test_led_spi_slave.sv]
// Purpose: Self-checking bench for the serial slave front end.
// Assumes: A bit is on the output 15.5 clocks after it entered, taken before the rise.
// Notes: Read data is fetched by a second frame, as a real master must do.
module test_led_spi_slave;
   import led_spi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   serial_in_type ser;
   logic serial_out_o;
   logic serial_out_oe_o;
   logic pwm_clock_sel_o;
   logic alt_oe;
   logic alt_sel;
   int fail_count = 0;
   int checks = 0;
   logic [15:0] rx;
   logic [7:0] d;

   // Clock at 250 MHz.
   always #2 mclk_i = ~mclk_i;

   led_spi_slave #(.OUT_DEFAULT_PWM(1'b0)) u_dut (.mclk_i(mclk_i), .reset_i(reset_i),
      .ser_i(ser), .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
      .pwm_clock_sel_o(pwm_clock_sel_o));
   led_spi_master u_master (.mclk_i(mclk_i), .sdo_i(serial_out_o), .ser_o(ser));
   // A second slave of the clock-input variant listens to the same frames.
   led_spi_slave #(.OUT_DEFAULT_PWM(1'b1)) u_dut_alt (.mclk_i(mclk_i), .reset_i(reset_i),
      .ser_i(ser), .serial_out_o(), .serial_out_oe_o(alt_oe), .pwm_clock_sel_o(alt_sel));

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      u_master.xfer({16'h0000, 1'b0, a, v}, 16, 1'b1, rx);
   endtask

   // The second frame is a harmless read; its second byte is the answer.
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      u_master.xfer({16'h0000, 1'b1, a, 8'h00}, 16, 1'b1, rx);
      u_master.xfer(32'h0000_8000, 16, 1'b1, rx);
      v = rx[7:0];
   endtask

   task automatic t_pin;
      check("oe after reset", 16'h0001, {15'h0000, serial_out_oe_o});
      check("sel after reset", 16'h0000, {15'h0000, pwm_clock_sel_o});
      check("alt oe after reset", 16'h0000, {15'h0000, alt_oe});
      check("alt sel after reset", 16'h0001, {15'h0000, alt_sel});
      wr(CFG_ADDR, 8'h80);
      check("oe in clock mode", 16'h0000, {15'h0000, serial_out_oe_o});
      check("sel in clock mode", 16'h0001, {15'h0000, pwm_clock_sel_o});
      wr(CFG_ADDR, 8'h00);
      check("oe back", 16'h0001, {15'h0000, serial_out_oe_o});
      check("alt oe back", 16'h0001, {15'h0000, alt_oe});
      $display("test pin done");
   endtask

   task automatic t_rw;
      rd(7'h26, d);
      check("reset value", 16'h0000, {8'h00, d});
      wr(7'h25, 8'hA5);
      rd(7'h25, d);
      check("read back", 16'h00A5, {8'h00, d});
      u_master.xfer(32'h0000_A53C, 16, 1'b1, rx);
      rd(7'h25, d);
      check("read data byte", 16'h00A5, {8'h00, d});
      $display("test rw done");
   endtask

   task automatic t_chain;
      u_master.xfer(32'h0000_1234, 16, 1'b1, rx);
      u_master.xfer(32'h0000_5678, 16, 1'b1, rx);
      check("pass through", 16'h1234, rx);
      $display("test chain done");
   endtask

   task automatic t_desel;
      d = serial_out_o;
      u_master.xfer(32'h0000_2500, 16, 1'b0, rx);
      check("out held", {15'h0000, d[0]}, {15'h0000, serial_out_o});
      u_master.xfer({16'h0000, 1'b1, 7'h25, 8'h00}, 16, 1'b1, rx);
      check("shift held", 16'h5678, rx);
      u_master.xfer(32'h0000_8000, 16, 1'b1, rx);
      check("ignored frame", 16'hA5A5, rx);
      $display("test deselect done");
   endtask

   task automatic t_long;
      u_master.xfer(32'h00FF_305A, 24, 1'b1, rx);
      rd(7'h30, d);
      check("last sixteen", 16'h005A, {8'h00, d});
      // Eight clocks only: the command byte is the data byte left by the frame before.
      u_master.xfer(32'h0000_0055, 16, 1'b1, rx);
      u_master.xfer(32'h0000_0077, 8, 1'b1, rx);
      rd(7'h55, d);
      check("short frame", 16'h0077, {8'h00, d});
      $display("test long done");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog sized well above the roughly 3000 cycles the tests take.
   initial begin
      #60us;
      fail_count++;
      final_report();
   end

   initial begin
      repeat (8) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      t_pin();
      t_rw();
      t_chain();
      t_desel();
      t_long();
      final_report();
   end
endmodule
